// ===== inc/frac_ext_pkg.sv
// package for the fraction extension and loop tuning word bank
// assumes a 24-bit programming word is delivered already latched with a strobe
package frac_ext_pkg;

  // ************************************************************
  // word layout
  // ************************************************************
  localparam int unsigned WORD_W = 24;
  localparam int unsigned CTRL_LSB = 0;
  localparam int unsigned CTRL_W = 4;
  localparam logic [3:0] CTRL_EXT = 4'hD;
  localparam logic [3:0] CTRL_TUNE = 4'hF;
  localparam logic [3:0] CTRL_WIDTH = 4'hB;
  // extension word fields
  localparam int unsigned NUM_EXT_LSB = 4;
  localparam int unsigned DEN_EXT_LSB = 14;
  localparam int unsigned EXT_W = 10;
  // tuning word fields
  localparam int unsigned TRIM_LSB = 5;
  localparam int unsigned TRIM_W = 3;
  localparam int unsigned BOOST_LSB = 10;
  localparam int unsigned BOOST_W = 2;
  localparam int unsigned DITHER_SELECT_LSB = 18;
  localparam int unsigned DITHER_SELECT_W = 2;
  // denominator width select sits in the mode control word
  localparam int unsigned WIDTH_SEL_BIT = 14;
  // fraction widths
  localparam int unsigned LOW_W = 12;
  localparam int unsigned FRAC_W = 22;

  // ************************************************************
  // field codes
  // ************************************************************
  localparam logic [2:0] TRIM_MIN = 3'h2;
  localparam logic [2:0] TRIM_MAX = 3'h3;
  localparam logic [2:0] TRIM_NOM = 3'h7;
  localparam logic [1:0] BOOST_DOUBLE = 2'h2;
  localparam logic [1:0] BOOST_OFF = 2'h3;
  localparam logic [1:0] DITHER_SELECT_ON = 2'h0;
  localparam logic [1:0] DITHER_SELECT_OFF = 2'h3;

  // ************************************************************
  // reset values, chosen safe
  // ************************************************************
  localparam logic [9:0] EXT_RST = 10'h000;
  localparam logic [2:0] TRIM_RST = 3'h7;
  localparam logic [1:0] BOOST_RST = 2'h3;
  localparam logic [1:0] DITHER_SELECT_RST = 2'h3;
  localparam logic WIDTH_RST = 1'b0;

  // trim decode state
  typedef enum logic [1:0]
  {
    TRIM_S_NOM = 2'b00,
    TRIM_S_MIN = 2'b01,
    TRIM_S_MAX = 2'b10,
    TRIM_S_RSV = 2'b11
  } trim_mode_type;

  // stored tuning fields
  typedef struct packed
  {
    logic [2:0] trim;
    logic [1:0] boost;
    logic [1:0] dither_select;
  } tune_fields_type;

  // effective fraction outputs
  typedef struct packed
  {
    logic [21:0] num;
    logic [21:0] den;
  } fraction_type;

endpackage

// ===== design/frac_ext_regs.sv
// fraction extension and loop tuning word bank of the synthesizer
// assumes word_i/word_load_i come from the serial shifter on clk_sys_i,
// and low numerator/denominator fields come from other words on this clock
// assumes fastlock_active_i is made by loop logic on the same clock
// words for other banks share the port and are ignored here by code
// reserved field codes are stored as written; boost and dither ones decode to off, trim ones to a reserved mode
// fraction and tuning outputs follow a word two clocks after it is taken, the width select output one clock
//
// Overview of operation
// - width select 0: 12-bit numerator, low only
// - width select 1: numerator = extension above low
// - width select 0: 12-bit denominator, extension ignored
// - width select 1: denominator = extension above low
// - trim codes 2 min, 3 max, 7 nominal
// - boost code 2 doubles pump in fastlock
// - boost has no effect outside fastlock
// - dither code 0 enables, 3 disables
// - width bit in mode word; 4095 or 4194303
`timescale 1ns/1ps

module frac_ext_regs
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // latched programming word
  input wire logic [23:0] word_i,
  input wire logic word_load_i,
  // low fields held in other words
  input wire logic [11:0] numerator_low_field_i,
  input wire logic [11:0] denominator_low_field_i,
  // loop status
  input wire logic fastlock_active_i,
  // effective fraction to the modulator
  output logic [21:0] fraction_numerator_o,
  output logic [21:0] fraction_denominator_o,
  output logic denominator_width_select_o,
  // tuning controls
  output logic [1:0] pump_trim_mode_o,
  output logic pump_current_double_o,
  output logic dither_enable_o
);

  // ************************************************************
  // state
  // ************************************************************
  // captured fields, written only by words that carry their code
  logic [9:0] numerator_extension_reg; // upper numerator bits
  logic [9:0] numerator_extension_next;
  logic [9:0] denominator_extension_reg; // upper denominator bits
  logic [9:0] denominator_extension_next;
  logic width_sel_reg; // denominator width select
  logic width_sel_next;
  frac_ext_pkg::tune_fields_type tune_reg; // stored tuning fields
  frac_ext_pkg::tune_fields_type tune_next;
  // output flops, one clock behind the captured fields
  frac_ext_pkg::fraction_type frac_reg; // registered effective fraction
  frac_ext_pkg::fraction_type frac_next;
  logic [1:0] trim_mode_reg; // decoded trim mode
  logic [1:0] trim_mode_next;
  logic double_reg; // pump doubling output
  logic double_next;
  logic dither_reg; // dither enable output
  logic dither_next;
  // combinational decode of the stored trim code
  frac_ext_pkg::trim_mode_type trim_dec; // trim decode

  // builds a fraction from extension and low field per width select
  // in narrow mode the upper bits read as zero, so a stale extension
  // left from an earlier wide setting never reaches the modulator
  function automatic logic [21:0] build_fraction(input logic wide, input logic [9:0] ext,
                                                 input logic [11:0] low);
    logic [21:0] value;
    value = {10'h000, low};
    if (wide)
    begin
      value = {ext, low};
    end
    return value;
  endfunction

  // ************************************************************
  // word capture
  // ************************************************************

  // decode the control nibble and load the matching fields
  // a word with a foreign code leaves every field as it was; there is
  // no error flag, the host simply addresses another bank
  always_comb
  begin
    // hold unless a word for this bank is taken
    numerator_extension_next = numerator_extension_reg;
    denominator_extension_next = denominator_extension_reg;
    width_sel_next = width_sel_reg;
    tune_next = tune_reg;
    if (word_load_i)
    begin
      case (word_i[frac_ext_pkg::CTRL_LSB +: frac_ext_pkg::CTRL_W])
        frac_ext_pkg::CTRL_EXT:
        begin
          // both extensions always travel together in one word
          numerator_extension_next = word_i[frac_ext_pkg::NUM_EXT_LSB +: frac_ext_pkg::EXT_W];
          denominator_extension_next = word_i[frac_ext_pkg::DEN_EXT_LSB +: frac_ext_pkg::EXT_W];
        end
        frac_ext_pkg::CTRL_TUNE:
        begin
          // spare bits of the tuning word are not stored
          tune_next.trim = word_i[frac_ext_pkg::TRIM_LSB +: frac_ext_pkg::TRIM_W];
          tune_next.boost = word_i[frac_ext_pkg::BOOST_LSB +: frac_ext_pkg::BOOST_W];
          tune_next.dither_select = word_i[frac_ext_pkg::DITHER_SELECT_LSB +: frac_ext_pkg::DITHER_SELECT_W];
        end
        frac_ext_pkg::CTRL_WIDTH:
        begin
          // only the width bit of the mode word is kept in this bank
          width_sel_next = word_i[frac_ext_pkg::WIDTH_SEL_BIT];
        end
        // other words belong elsewhere
        default:
        begin
          width_sel_next = width_sel_reg;
        end
      endcase
    end
  end

  // register captured fields
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      // safe settings: narrow fraction, nominal trim, boost and dither off
      numerator_extension_reg <= frac_ext_pkg::EXT_RST;
      denominator_extension_reg <= frac_ext_pkg::EXT_RST;
      width_sel_reg <= frac_ext_pkg::WIDTH_RST;
      tune_reg <= '{trim: frac_ext_pkg::TRIM_RST, boost: frac_ext_pkg::BOOST_RST,
                    dither_select: frac_ext_pkg::DITHER_SELECT_RST};
    end
    else
    begin
      // take the decoded next values
      numerator_extension_reg <= numerator_extension_next;
      denominator_extension_reg <= denominator_extension_next;
      width_sel_reg <= width_sel_next;
      tune_reg <= tune_next;
    end
  end

  // ************************************************************
  // effective controls
  // ************************************************************

  // trim decode, reserved codes flagged
  // codes 0, 1, 4, 5 and 6 are reserved; they show as a mode of their
  // own so the pump logic can tell them from a real setting
  always_comb
  begin
    case (tune_reg.trim)
      frac_ext_pkg::TRIM_MIN: trim_dec = frac_ext_pkg::TRIM_S_MIN;
      frac_ext_pkg::TRIM_MAX: trim_dec = frac_ext_pkg::TRIM_S_MAX;
      frac_ext_pkg::TRIM_NOM: trim_dec = frac_ext_pkg::TRIM_S_NOM;
      default: trim_dec = frac_ext_pkg::TRIM_S_RSV;
    endcase
  end

  // compute next output values
  // the low fields and fastlock status are sampled here, so they reach
  // the ports one clock after they change; a word reaches them in two
  always_comb
  begin
    frac_next.num = build_fraction(width_sel_reg, numerator_extension_reg,
                                   numerator_low_field_i);
    frac_next.den = build_fraction(width_sel_reg, denominator_extension_reg,
                                   denominator_low_field_i);
    trim_mode_next = trim_dec;
    // doubling only during fastlock
    // reserved boost codes fall through as no doubling
    double_next = fastlock_active_i && (tune_reg.boost == frac_ext_pkg::BOOST_DOUBLE);
    // dither only on code 0
    // reserved codes 1 and 2 leave dithering off
    dither_next = (tune_reg.dither_select == frac_ext_pkg::DITHER_SELECT_ON);
  end

  // register outputs
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      // quiet outputs while reset is held
      frac_reg <= '0;
      trim_mode_reg <= 2'h0;
      double_reg <= 1'b0;
      dither_reg <= 1'b0;
    end
    else
    begin
      // every output flop reloads on each clock
      frac_reg <= frac_next;
      trim_mode_reg <= trim_mode_next;
      double_reg <= double_next;
      dither_reg <= dither_next;
    end
  end

  // drive ports from flops
  // no logic stands between a flop and its port
  assign fraction_numerator_o = frac_reg.num;
  assign fraction_denominator_o = frac_reg.den;
  assign denominator_width_select_o = width_sel_reg;
  assign pump_trim_mode_o = trim_mode_reg;
  assign pump_current_double_o = double_reg;
  assign dither_enable_o = dither_reg;

endmodule

// ===== testbench/frac_ext_regs_chk.sv
// checker of the fraction extension and tuning word bank
// assumes it is bound onto frac_ext_regs
`timescale 1ns/1ps
module frac_ext_regs_chk
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // design inputs
  input wire logic word_load_i,
  input wire logic fastlock_active_i,
  input wire logic [23:0] word_i,
  input wire logic [11:0] numerator_low_field_i,
  input wire logic [11:0] denominator_low_field_i,
  // design outputs
  input wire logic [21:0] fraction_numerator_o,
  input wire logic [21:0] fraction_denominator_o,
  input wire logic denominator_width_select_o,
  input wire logic pump_current_double_o,
  input wire logic dither_enable_o,
  input wire logic [1:0] pump_trim_mode_o
);
  // every property samples on the rising edge and rests in reset
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // mirrored stored fields
  logic [9:0] nx, dx;
  logic [2:0] tr;
  logic [1:0] bo, di, tm;
  logic [3:0] cd;
  logic wb;
  assign cd = word_i[3:0];
  assign wb = word_i[14];
  // only matching control codes touch the mirror
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      {dx, nx, tr, bo, di} <= {20'h0, 3'h7, 2'h3, 2'h3};
    else if (word_load_i && cd == frac_ext_pkg::CTRL_EXT)
      {dx, nx} <= word_i[23:4];
    else if (word_load_i && cd == frac_ext_pkg::CTRL_TUNE)
      {tr, bo, di} <= {word_i[7:5], word_i[11:10], word_i[19:18]};
  // trim code to mode
  always_comb
    case (tr)
      3'h7: tm = 2'h0;
      3'h2: tm = 2'h1;
      3'h3: tm = 2'h2;
      default: tm = 2'h3;
    endcase
  num_frac_a: assert property ($past(arst_n_i) |-> fraction_numerator_o ==
    {($past(denominator_width_select_o) ? $past(nx) : 10'h0), $past(numerator_low_field_i)})
    else $error("bad numerator");
  den_frac_a: assert property ($past(arst_n_i) |-> fraction_denominator_o ==
    {($past(denominator_width_select_o) ? $past(dx) : 10'h0), $past(denominator_low_field_i)})
    else $error("bad denominator");
  width_set_a: assert property (word_load_i && cd == frac_ext_pkg::CTRL_WIDTH |=>
    denominator_width_select_o == $past(wb)) else $error("width not taken");
  width_hold_a: assert property (!(word_load_i && cd == frac_ext_pkg::CTRL_WIDTH) |=>
    $stable(denominator_width_select_o)) else $error("width changed");
  trim_map_a: assert property (pump_trim_mode_o == $past(tm)) else $error("bad trim");
  boost_dbl_a: assert property (pump_current_double_o ==
    ($past(fastlock_active_i) && $past(bo) == 2'h2)) else $error("bad double");
  steady_pump_a: assert property (!$past(fastlock_active_i) |-> !pump_current_double_o)
    else $error("double outside fastlock");
  dither_sel_a: assert property (dither_enable_o == ($past(di) == 2'h0))
    else $error("bad dither");
endmodule
bind frac_ext_regs frac_ext_regs_chk frac_ext_regs_chk_i
(
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .word_load_i(word_load_i), .word_i(word_i),
  .fastlock_active_i(fastlock_active_i), .numerator_low_field_i(numerator_low_field_i),
  .denominator_low_field_i(denominator_low_field_i),
  .fraction_numerator_o(fraction_numerator_o), .fraction_denominator_o(fraction_denominator_o),
  .denominator_width_select_o(denominator_width_select_o), .pump_trim_mode_o(pump_trim_mode_o),
  .pump_current_double_o(pump_current_double_o), .dither_enable_o(dither_enable_o)
);

// ===== testbench/host_model.sv
// host model: hands the bank one programming word per cycle
// assumes the bench calls its tasks; changes on the falling edge
`timescale 1ns/1ps
module host_model
(
  // clock
  input wire logic clk_sys_i,
  // programming word
  output logic [23:0] word_o,
  output logic word_load_o
);
  initial
  begin
    word_o = 24'h0;
    word_load_o = 1'b0;
  end
  // present a word; load stays high for a following send
  task automatic send(input logic [23:0] w);
    @(negedge clk_sys_i);
    word_o = w;
    word_load_o = 1'b1;
  endtask
  // release the load; data shows the inverse of the last word
  task automatic idle();
    @(negedge clk_sys_i);
    word_o = ~word_o;
    word_load_o = 1'b0;
  endtask
  // tuning word, spare bits zero, reserved boost codes become off
  task automatic tune(input logic [2:0] t, input logic [1:0] b, input logic [1:0] h);
    send({4'h0, h, 6'h0, (b < 2'h2) ? 2'h3 : b, 2'h0, t, 1'h0, frac_ext_pkg::CTRL_TUNE});
  endtask
endmodule

// ===== testbench/frac_ext_regs_tb.sv
// self-checking bench of the fraction extension and tuning word bank
// assumes the host model drives the word port and the checker is bound
`timescale 1ns/1ps
module frac_ext_regs_tb;
  logic clk_sys_i, arst_n_i, fl, ld, width_o, dbl_o, dither_select_o;
  logic [23:0] wd;
  logic [11:0] nl, dl;
  logic [21:0] num_o, den_o;
  logic [1:0] trim_o;
  logic [9:0] x;
  logic [1:0] dc;
  int mismatches, checked, seed;
  frac_ext_regs frac_ext_regs_i
  (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .word_i(wd), .word_load_i(ld),
    .numerator_low_field_i(nl), .denominator_low_field_i(dl), .fastlock_active_i(fl),
    .fraction_numerator_o(num_o), .fraction_denominator_o(den_o),
    .denominator_width_select_o(width_o), .pump_trim_mode_o(trim_o),
    .pump_current_double_o(dbl_o), .dither_enable_o(dither_select_o)
  );
  host_model host_model_i (.clk_sys_i(clk_sys_i), .word_o(wd), .word_load_o(ld));
  // 200 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic cmp(input logic [21:0] got, input logic [21:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  // expected fraction and trim mode
  function automatic logic [21:0] frac(input logic w, input logic [9:0] e, input logic [11:0] l);
    return {(w ? e : 10'h0), l};
  endfunction
  function automatic logic [1:0] etrim(input logic [2:0] c);
    return (c == 3'h7) ? 2'h0 : (c == 3'h2) ? 2'h1 : (c == 3'h3) ? 2'h2 : 2'h3;
  endfunction
  // release the word, then let the two-cycle answer land
  task automatic settle();
    host_model_i.idle();
    repeat (3) @(negedge clk_sys_i);
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    {seed, mismatches, checked} = {43311, 64'h0};
    {arst_n_i, fl, nl, dl} = 26'h0;
    repeat (10) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    cmp({trim_o, dbl_o, dither_select_o, width_o}, 22'h0);
    // mode then extension back to back, corners then random
    for (int i = 0; i < 12; i++)
    begin
      x = (i < 4) ? {10{i[0]}} : 10'($random(seed));
      host_model_i.send({9'h0, i[1], 10'h0, frac_ext_pkg::CTRL_WIDTH});
      host_model_i.send({~x, x, frac_ext_pkg::CTRL_EXT});
      nl = (i < 4) ? {12{i[0]}} : 12'($random(seed));
      dl = ~nl;
      settle();
      cmp(width_o, i[1]);
      cmp(num_o, frac(i[1], x, nl));
      cmp(den_o, frac(i[1], ~x, dl));
    end
    $display("test fraction done");
    // tuning checked with denominator 1000 and numerator 1; dither follows its code alone
    {nl, dl} = {12'h001, 12'h3E8};
    for (int t = 0; t < 8; t++)
    begin
      fl = t[2];
      // dither codes 0 to 3, reserved ones included
      dc = t[1] ? 2'h0 : (t[0] ? 2'h3 : {t[2], ~t[2]});
      host_model_i.tune(3'(t), t[0] ? 2'h2 : 2'h3, dc);
      settle();
      cmp(trim_o, etrim(3'(t)));
      cmp(dbl_o, t[0] & t[2]);
      cmp(dither_select_o, t[1]);
    end
    $display("test tuning done");
    // back-to-back words with foreign codes leave everything alone
    for (int r = 0; r < 8; r++)
      host_model_i.send({20'($random(seed)), 4'(r)});
    settle();
    cmp({trim_o, dbl_o, dither_select_o, width_o}, 22'h7);
    cmp(num_o, frac(1'b1, x, nl));
    cmp(den_o, frac(1'b1, ~x, dl));
    $display("test foreign codes done");
    // mid-run reset brings back the safe fields, extension included
    arst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    host_model_i.send({9'h0, 1'b1, 10'h0, frac_ext_pkg::CTRL_WIDTH});
    settle();
    cmp({trim_o, dbl_o, dither_select_o, width_o}, 22'h1);
    cmp(num_o, frac(1'b1, 10'h0, nl));
    cmp(den_o, frac(1'b1, 10'h0, dl));
    $display("test reset done");
    print_verdict();
  end
endmodule
